/* rtl/sac_clkdiv.sv */
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_clkdiv (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_rc_clk,
   sac_conv_if.div conv
);
   import sac_pkg::*;
   sac_div_state_type st;
   sac_div_state_type next_st;

   // Half bit-period length in system clocks for each divided source.
   function automatic logic [5:0] half_count(input logic [2:0] sel);
      case (sel)
         3'h0: half_count = `SAC_HALF_DIV2;
         3'h4: half_count = `SAC_HALF_DIV4;
         3'h1: half_count = `SAC_HALF_DIV8;
         3'h5: half_count = `SAC_HALF_DIV16;
         3'h2: half_count = `SAC_HALF_DIV32;
         3'h6: half_count = `SAC_HALF_DIV64;
         default: half_count = `SAC_HALF_DIV2;
      endcase
   endfunction

   // Each tick marks half a bit period, so the odd half of the 11.5 periods fits.
   always_comb begin
      next_st = st;
      next_st.rc_sync = {st.rc_sync[1:0], i_rc_clk};
      next_st.tick = 1'b0;
      if (!conv.run) begin
         next_st.cnt = 6'h00;
      end else if (conv.clk_sel[1:0] == `SAC_CLK_RC) begin
         next_st.cnt = 6'h00;
         next_st.tick = st.rc_sync[2] ^ st.rc_sync[1];
      end else if (st.cnt + 6'h01 >= half_count(conv.clk_sel)) begin
         next_st.cnt = 6'h00;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 6'h01;
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign conv.half_tick = st.tick;
endmodule

/* rtl/sac_consts.svh */
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// Contract
// - Produce a ten-bit successive-approximation result into the result byte pair.
// - Offer seven sources: four external pins, temperature, DAC and reference buffer.
// - Channel select routes at most one source to the shared sample-and-hold.
// - Positive reference is the reference pin or supply; negative is always ground.
// - Clock select codes give system clock divided by 2 to 64, or RC.
// - One bit per bit period; a whole conversion takes eleven and a half periods.
// - Divided clocks follow the system clock; the RC clock is independent of it.
// - Conversions run during sleep only with the internal RC clock selected.
// - The completion flag is set at every conversion end, whatever the enable.
// - Hardware never clears the completion flag; software clears it explicitly.
// - With the converter interrupt enabled, completion during sleep wakes the device.
// - After wake, the instruction after sleep executes before anything else.
// - Enable plus peripheral enable with global clear resumes inline; all three vector.
// - The justify bit places the result left or right across the byte pair.
// - Codes 0-3 pins, 29 temperature, 30 DAC, 31 buffer; others connect nothing.
// - Writing one to the status bit while enabled starts; it reads one while busy.
// - At completion clear the status bit, set the flag and load the result.
// - Sleep with a non-RC clock aborts and powers the converter off, enable kept.
`define SAC_ADDR_CTRL0 3'h0
`define SAC_ADDR_CTRL1 3'h1
`define SAC_ADDR_RES_HI 3'h2
`define SAC_ADDR_RES_LO 3'h3
`define SAC_ADDR_PFLAG1 3'h4
`define SAC_ADDR_PEN1 3'h5
`define SAC_ADDR_IRQCTL 3'h6
`define SAC_BIT_GO 1
`define SAC_BIT_ON 0
`define SAC_BIT_JUSTIFY 7
`define SAC_BIT_FLAG 6
`define SAC_BIT_IRQ_EN 6
`define SAC_BIT_GIE 7
`define SAC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define SAC_RST_BYTE 8'h00
`define SAC_CLK_RC 2'h3
`define SAC_REF_PIN 2'h2
`define SAC_CHS_EXT_MAX 5'h03
`define SAC_CHS_TEMP 5'h1D
`define SAC_CHS_DAC 5'h1E
`define SAC_CHS_REFBUF 5'h1F
`define SAC_HALF_DIV2 6'h01
`define SAC_HALF_DIV4 6'h02
`define SAC_HALF_DIV8 6'h04
`define SAC_HALF_DIV16 6'h08
`define SAC_HALF_DIV32 6'h10
`define SAC_HALF_DIV64 6'h20
`define SAC_SEQ_SAMPLE 5'h03
`define SAC_SEQ_LAST 5'h17
`define SAC_MSB_MASK 10'h200
`endif

/* rtl/sac_conv_if.sv */
`timescale 1ns/1ps
interface sac_conv_if;
   logic run;
   logic [2:0] clk_sel;
   logic half_tick;
   logic start;
   logic abort;
   logic cmp;
   logic done;
   logic [9:0] result;
   logic [9:0] trial;
   logic sampling;
   modport ctl(output run, clk_sel, start, abort, cmp, input done, result, trial, sampling);
   modport div(input run, clk_sel, output half_tick);
   modport sar(input run, half_tick, start, abort, cmp, output done, result, trial, sampling);
endinterface

/* rtl/sac_pkg.sv */
package sac_pkg;
   typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_CONVERT} sac_seq_type;
   typedef struct packed {
      logic [4:0] input_channel_select;
      logic go;
      logic on;
      logic justify;
      logic [2:0] clk_sel;
      logic [1:0] pref;
      logic flag;
      logic irq_en;
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic [9:0] result;
      logic [7:0] rdata;
      logic sleeping;
      logic post_wake;
      logic off_by_sleep;
      logic wake;
      logic vector_req;
      logic [6:0] mux;
      logic vref_pin;
      logic powered;
      logic start;
      logic abort;
      logic cmp_sync;
   } sac_top_state_type;
   typedef struct packed {
      logic [5:0] cnt;
      logic [2:0] rc_sync;
      logic tick;
   } sac_div_state_type;
   typedef struct packed {
      sac_seq_type seq;
      logic [4:0] phase;
      logic [9:0] mask;
      logic [9:0] trial;
      logic [9:0] result;
      logic done;
      logic sampling;
   } sac_sar_state_type;
endpackage

/* rtl/sac_sar.sv */
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_sar (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   sac_conv_if.sar conv
);
   import sac_pkg::*;
   sac_sar_state_type st;
   sac_sar_state_type next_st;
   logic [9:0] kept;

   // Three half periods of sampling, then one decision every two half periods.
   always_comb begin
      kept = conv.cmp ? st.trial : (st.trial & ~st.mask);
      next_st = st;
      next_st.done = 1'b0;
      if (conv.abort || !conv.run) begin
         next_st.seq = SAC_IDLE;
         next_st.sampling = 1'b0;
      end else if (conv.start) begin
         next_st.seq = SAC_SAMPLE;
         next_st.phase = 5'h00;
         next_st.mask = `SAC_MSB_MASK;
         next_st.trial = `SAC_MSB_MASK;
         next_st.sampling = 1'b1;
      end else if (conv.half_tick) begin
         case (st.seq)
            SAC_SAMPLE: begin
               next_st.phase = st.phase + 5'h01;
               if (next_st.phase == `SAC_SEQ_SAMPLE) begin
                  next_st.seq = SAC_CONVERT;
                  next_st.sampling = 1'b0;
               end
            end
            SAC_CONVERT: begin
               next_st.phase = st.phase + 5'h01;
               if (next_st.phase[0]) begin
                  next_st.mask = st.mask >> 1;
                  next_st.trial = kept | (st.mask >> 1);
                  if (next_st.phase == `SAC_SEQ_LAST) begin
                     next_st.result = kept;
                     next_st.trial = kept;
                     next_st.done = 1'b1;
                     next_st.seq = SAC_IDLE;
                  end
               end
            end
            default: begin
               next_st.seq = SAC_IDLE;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign conv.done = st.done;
   assign conv.result = st.result;
   assign conv.trial = st.trial;
   assign conv.sampling = st.sampling;
endmodule

/* rtl/sac_top.sv */
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_top (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [7:0] o_rdata,
   input wire logic i_sleep_enter,
   input wire logic i_sleep_exit,
   input wire logic i_instr_retired,
   input wire logic i_rc_clk,
   input wire logic i_cmp_high,
   output logic [6:0] o_mux_sel,
   output logic o_vref_from_pin,
   output logic o_conv_powered,
   output logic o_sample_hold,
   output logic [9:0] o_dac_code,
   output logic o_wake,
   output logic o_vector_req
);
   import sac_pkg::*;

   // ----------------------------------------------------------------
   // State and sub-blocks
   // ----------------------------------------------------------------

   sac_top_state_type st;
   sac_top_state_type next_st;
   sac_conv_if conv();

   // The divider turns the selected source into half bit-period ticks.
   sac_clkdiv u_clkdiv (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_rc_clk(i_rc_clk),
      .conv(conv)
   );

   // The sequencer walks the ten trial bits against the comparator.
   sac_sar u_sar (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .conv(conv)
   );

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // One-hot source select; unassigned codes leave every switch open.
   // Bits 3:0 are the external pins, 4 temperature, 5 DAC, 6 buffer.
   function automatic logic [6:0] decode_channel(input logic [4:0] input_channel_select);
      logic [6:0] sel;
      sel = 7'h00;
      if (input_channel_select <= `SAC_CHS_EXT_MAX) begin
         sel[input_channel_select[1:0]] = 1'b1;
      end else if (input_channel_select == `SAC_CHS_TEMP) begin
         sel[4] = 1'b1;
      end else if (input_channel_select == `SAC_CHS_DAC) begin
         sel[5] = 1'b1;
      end else if (input_channel_select == `SAC_CHS_REFBUF) begin
         sel[6] = 1'b1;
      end
      return sel;
   endfunction

   // Result byte pair as {high, low} for either placement.
   // Right placement zeroes the six top bits of the high byte, left placement
   // zeroes the six bottom bits of the low byte.
   function automatic logic [15:0] place_result(input logic [9:0] res, input logic right);
      logic [15:0] pair;
      if (right) begin
         pair = {6'h00, res};
      end else begin
         pair = {res, 6'h00};
      end
      return pair;
   endfunction

   // True when the internal RC oscillator drives the conversion clock.
   function automatic logic uses_rc(input logic [2:0] sel);
      return sel[1:0] == `SAC_CLK_RC;
   endfunction

   // ----------------------------------------------------------------
   // Links to the sub-blocks
   // ----------------------------------------------------------------

   // The sequencer runs only when enabled and not parked by sleep. This is
   // what keeps the divider and sequencer quiet while the enable is clear.
   assign conv.run = st.on & ~st.off_by_sleep;
   assign conv.clk_sel = st.clk_sel;
   assign conv.start = st.start;
   assign conv.abort = st.abort;
   // One stage keeps up with divide-by-2 decisions.
   assign conv.cmp = st.cmp_sync;

   // ----------------------------------------------------------------
   // Control, status and register access
   // ----------------------------------------------------------------

   // Single next-state process. Later assignments override earlier ones,
   // so hardware events are placed after software writes and win the race.
   always_comb begin
      logic [15:0] pair;
      pair = place_result(st.result, st.justify);
      next_st = st;
      next_st.start = 1'b0;
      next_st.abort = 1'b0;
      next_st.wake = 1'b0;
      next_st.rdata = `SAC_RST_BYTE;
      next_st.cmp_sync = i_cmp_high;

      // Register writes from the core.
      if (i_we) begin
         case (i_addr)
            `SAC_ADDR_CTRL0: begin
               next_st.input_channel_select = i_wdata[6:2];
               next_st.on = i_wdata[`SAC_BIT_ON];
               next_st.off_by_sleep = 1'b0;
               if (!i_wdata[`SAC_BIT_ON]) begin
                  // Turning the converter off drops any conversion in flight.
                  next_st.go = 1'b0;
                  next_st.abort = st.go;
               end else if (i_wdata[`SAC_BIT_GO] && !st.go) begin
                  next_st.go = 1'b1;
                  next_st.start = 1'b1;
               end else if (!i_wdata[`SAC_BIT_GO] && st.go) begin
                  // Software termination keeps the partial code; unresolved
                  // bits still hold their trial pattern.
                  next_st.go = 1'b0;
                  next_st.abort = 1'b1;
                  next_st.result = conv.trial;
               end
            end
            `SAC_ADDR_CTRL1: begin
               next_st.justify = i_wdata[`SAC_BIT_JUSTIFY];
               next_st.clk_sel = i_wdata[6:4];
               next_st.pref = i_wdata[1:0];
            end
            `SAC_ADDR_PFLAG1: begin
               // The only path apart from reset that ever clears the flag.
               next_st.flag = i_wdata[`SAC_BIT_FLAG];
            end
            `SAC_ADDR_PEN1: begin
               next_st.irq_en = i_wdata[`SAC_BIT_IRQ_EN];
            end
            `SAC_ADDR_IRQCTL: begin
               next_st.global_irq_enable = i_wdata[`SAC_BIT_GIE];
               next_st.peripheral_irq_enable = i_wdata[`SAC_BIT_PERIPHERAL_IRQ_ENABLE];
            end
            default: begin
            end
         endcase
      end

      // The core retiring the first instruction after wake releases vectoring.
      if (i_instr_retired) begin
         next_st.post_wake = 1'b0;
      end

      // Another wake source ends sleep; the converter comes back on.
      if (i_sleep_exit && st.sleeping) begin
         next_st.sleeping = 1'b0;
         next_st.off_by_sleep = 1'b0;
         next_st.post_wake = 1'b1;
      end

      // Entering sleep. A system-clock derived conversion clock stops with
      // the core, so the conversion is dropped and the converter parked while
      // the enable bit itself stays set.
      if (i_sleep_enter) begin
         next_st.sleeping = 1'b1;
         if (!uses_rc(st.clk_sel)) begin
            next_st.go = 1'b0;
            next_st.abort = st.go;
            next_st.off_by_sleep = 1'b1;
         end
      end

      // Completion. A late done after an abort is ignored because the
      // status bit is already low by then.
      if (conv.done && st.go) begin
         next_st.go = 1'b0;
         next_st.result = conv.result;
         next_st.flag = 1'b1;
         if (st.sleeping) begin
            if (st.irq_en) begin
               next_st.wake = 1'b1;
               next_st.sleeping = 1'b0;
               next_st.post_wake = 1'b1;
            end else begin
               // Without a wake the converter powers down after the result.
               next_st.off_by_sleep = 1'b1;
            end
         end
      end

      // Read data stand for exactly the cycle after the read strobe.
      if (i_re) begin
         case (i_addr)
            `SAC_ADDR_CTRL0: next_st.rdata = {1'b0, st.input_channel_select, st.go, st.on};
            `SAC_ADDR_CTRL1: next_st.rdata = {st.justify, st.clk_sel, 2'b00, st.pref};
            `SAC_ADDR_RES_HI: next_st.rdata = pair[15:8];
            `SAC_ADDR_RES_LO: next_st.rdata = pair[7:0];
            `SAC_ADDR_PFLAG1: next_st.rdata = {1'b0, st.flag, 6'h00};
            `SAC_ADDR_PEN1: next_st.rdata = {1'b0, st.irq_en, 6'h00};
            `SAC_ADDR_IRQCTL: next_st.rdata = {st.global_irq_enable, st.peripheral_irq_enable, 6'h00};
            default: next_st.rdata = `SAC_RST_BYTE;
         endcase
      end

      // Registered views that leave the block.
      // Seven sources, one switch each; reserved codes close none.
      next_st.mux = decode_channel(next_st.input_channel_select);
      // Negative reference is ground by construction; only ref+ is chosen.
      next_st.vref_pin = next_st.pref == `SAC_REF_PIN;
      next_st.powered = next_st.on & ~next_st.off_by_sleep;
      // The vector request is held back while asleep and until the
      // instruction after the sleep has retired. With the global enable
      // clear the core simply resumes inline after that instruction.
      next_st.vector_req = next_st.flag & next_st.irq_en & next_st.peripheral_irq_enable & next_st.global_irq_enable & ~next_st.sleeping
                           & ~next_st.post_wake;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // All control and status clear together under reset, which also
   // terminates any conversion because the start and run lines drop.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Every output is a flip-flop, here or inside the sequencer.
   assign o_rdata = st.rdata;
   assign o_mux_sel = st.mux;
   assign o_vref_from_pin = st.vref_pin;
   assign o_conv_powered = st.powered;
   assign o_sample_hold = conv.sampling;
   assign o_dac_code = conv.trial;
   assign o_wake = st.wake;
   assign o_vector_req = st.vector_req;
endmodule

/* test/sac_analog_model.sv */
`timescale 1ns/1ps
// ----------
// Analog source and comparator stand-in
// ----------
module sac_analog_model (
   input wire logic i_clk,
   input wire logic [6:0] i_mux_sel,
   input wire logic i_sample,
   input wire logic [9:0] i_dac_code,
   output logic o_cmp_high
);
   logic [9:0] level [7];
   logic [9:0] held = 10'h000;
   logic [9:0] pick;
   // An open switch grounds the node, so reserved codes convert to zero.
   always_comb begin
      pick = 10'h000;
      for (int k = 0; k < 7; k++) begin
         if (i_mux_sel[k]) begin
            pick = level[k];
         end
      end
   end
   // The node tracks while sampling, then keeps its charge.
   always @(posedge i_clk) begin
      if (i_sample) begin
         held <= pick;
      end
   end
   assign o_cmp_high = (held >= i_dac_code);
endmodule

/* test/sac_top_monitor.sv */
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module sac_top_monitor (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   input wire logic i_sleep_enter,
   input wire logic i_instr_retired,
   input wire logic [6:0] o_mux_sel,
   input wire logic o_vref_from_pin,
   input wire logic o_conv_powered,
   input wire logic o_sample_hold,
   input wire logic o_wake,
   input wire logic o_vector_req
);
   logic [7:0] sh0;
   logic [7:0] sh1;
   logic [7:0] sh5;
   logic [7:0] sh6;
   logic hold;
   // Shadows follow the write strobes, never the design's state.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {sh0, sh1, sh5, sh6, hold} <= '0;
      end else begin
         sh0 <= (i_we && i_addr == 3'h0) ? i_wdata : sh0;
         sh1 <= (i_we && i_addr == 3'h1) ? i_wdata : sh1;
         sh5 <= (i_we && i_addr == 3'h5) ? i_wdata : sh5;
         sh6 <= (i_we && i_addr == 3'h6) ? i_wdata : sh6;
         hold <= i_sleep_enter ? 1'h1 : (i_instr_retired ? 1'h0 : hold);
      end
   end
   function automatic logic [6:0] oh(input logic [4:0] c);
      if (c <= 5'h03) return 7'h01 << c;
      if (c >= 5'h1D) return 7'h10 << (c - 5'h1D);
      return 7'h00;
   endfunction
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   sequence s_sleep_fast;
      i_sleep_enter && sh1[5:4] != 2'h3;
   endsequence
   sequence s_off;
      !sh0[0] [*3];
   endsequence
   property p_mux_onehot;
      $onehot0(o_mux_sel);
   endproperty
   property p_mux_code;
      i_we && i_addr == 3'h0 |=> ##1 o_mux_sel == oh(sh0[6:2]);
   endproperty
   property p_vref;
      i_we && i_addr == 3'h1 |=> ##1 o_vref_from_pin == (sh1[1:0] == 2'h2);
   endproperty
   property p_wake_pulse;
      o_wake |=> !o_wake;
   endproperty
   property p_wake_ie;
      !sh5[6] [*3] |-> !o_wake;
   endproperty
   property p_vector;
      !(sh5[6] && sh6[7] && sh6[6]) [*3] |-> !o_vector_req;
   endproperty
   property p_vec_hold;
      hold && $past(hold) |-> !o_vector_req;
   endproperty
   property p_sleep_abort;
      s_sleep_fast |-> ##[1:3] (!o_conv_powered && !o_sample_hold);
   endproperty
   property p_off_idle;
      s_off |-> !o_conv_powered && !o_sample_hold;
   endproperty
   a_mux_onehot: assert property (p_mux_onehot) else $error("source switch not one-hot");
   a_mux_code: assert property (p_mux_code) else $error("source switch wrong for code");
   a_vref: assert property (p_vref) else $error("reference select wrong");
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
   a_wake_ie: assert property (p_wake_ie) else $error("wake without interrupt enable");
   a_vector: assert property (p_vector) else $error("vector without all enables");
   a_vec_hold: assert property (p_vec_hold) else $error("vector before first instruction");
   a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not stop converter");
   a_off_idle: assert property (p_off_idle) else $error("converter active while off");
endmodule
bind sac_top sac_top_monitor sac_top_monitor_i (.*);

/* test/sar_adc_control_sequencer_tb.sv */
`timescale 1ns/1ps
// ----------
// Converter control bench
// ----------
module sar_adc_control_sequencer_tb;
   import sac_pkg::*;
   logic i_core_clk = 1'h0;
   logic i_arst_n = 1'h0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_we = 1'h0, i_re = 1'h0, i_sleep_enter = 1'h0, i_sleep_exit = 1'h0, i_instr_retired = 1'h0;
   logic i_rc_clk = 1'h0;
   logic [7:0] o_rdata;
   logic [6:0] o_mux_sel;
   logic [9:0] o_dac_code;
   logic i_cmp_high, o_vref_from_pin, o_conv_powered, o_sample_hold, o_wake, o_vector_req;
   int n_errors = 0, checked = 0, wakes = 0;
   int exp_q[$];
   logic [31:0] seed = 32'h9138AC10;
   logic [7:0] d;
   logic [4:0] codes [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
   logic [6:0] mux_exp [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h00, 7'h00, 7'h10, 7'h20, 7'h40};
   logic [2:0] clks [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
   logic [4:0] chans [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E, 5'h1F};
   // An unrelated oscillator period varies the crossing phase.
   always #50 i_core_clk = ~i_core_clk;
   always #370 i_rc_clk = ~i_rc_clk;
   sac_top sac_top_i (.*);
   sac_analog_model sac_analog_model_i (.i_clk(i_core_clk), .i_mux_sel(o_mux_sel), .i_sample(o_sample_hold),
      .i_dac_code(o_dac_code), .o_cmp_high(i_cmp_high));
   // Counting shows a missing or doubled wake.
   always @(posedge i_core_clk) begin
      wakes = wakes + int'(o_wake === 1'h1);
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] fmt(input int v, input logic just, input logic hi);
      if (just) return hi ? 8'(v >> 8) : 8'(v);
      return hi ? 8'(v >> 2) : 8'(v << 6);
   endfunction
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      chk_pin(n, 10'(e), 10'(g));
   endtask
   task automatic chk_pin(input string n, input logic [9:0] e, input logic [9:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge i_core_clk);
      i_we <= 1'h1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_core_clk);
      i_we <= 1'h0;
   endtask
   // Read data stand one cycle after the strobe; take it mid-cycle.
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge i_core_clk);
      i_re <= 1'h1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_re <= 1'h0;
      @(negedge i_core_clk);
      v = o_rdata;
   endtask
   task automatic pulse(input int w);
      @(posedge i_core_clk);
      i_sleep_enter <= (w == 0);
      i_sleep_exit <= (w == 1);
      i_instr_retired <= (w == 2);
      @(posedge i_core_clk);
      i_sleep_enter <= 1'h0;
      i_sleep_exit <= 1'h0;
      i_instr_retired <= 1'h0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask
   task automatic flag_clear();
      settle(50);
      rd(3'h4, d);
      chk_reg("flag kept", 8'h40, d);
      wr(3'h4, 8'h00);
      rd(3'h4, d);
      chk_reg("flag cleared", 8'h00, d);
   endtask
   // Configure, wait, start, poll busy, compare the result pair.
   task automatic conv(input logic [2:0] cs, input logic just, input logic [4:0] ch, input int k, input logic sl);
      int v, n, h;
      time t0;
      seed = lfsr(seed);
      v = int'(seed[9:0]);
      sac_analog_model_i.level[k] = seed[9:0];
      exp_q.push_back(v);
      h = 1 << {cs[1:0], cs[2]};
      wr(3'h1, {just, cs, 4'h0});
      wr(3'h0, {1'h0, ch, 2'h1});
      settle((ch == 5'h1D) ? 2000 : 20);
      wr(3'h0, {1'h0, ch, 2'h3});
      t0 = $time;
      if (sl) begin
         pulse(0);
      end
      n = 0;
      rd(3'h0, d);
      chk_reg("busy", {1'h0, ch, 2'h3}, d);
      while (d[1] === 1'h1 && n < 3000) begin
         rd(3'h0, d);
         n++;
      end
      n = int'(($time - t0) / 100);
      if (cs[1:0] != 2'h3) begin
         chk_pin("conversion time", 10'h001, 10'(n >= 22 * h && n <= 24 * h + 16));
      end
      chk_reg("done", {1'h0, ch, 2'h1}, d);
      rd(3'h4, d);
      chk_reg("flag set", 8'h40, d);
      v = exp_q.pop_front();
      rd(3'h2, d);
      chk_reg("result high", fmt(v, just, 1'h1), d);
      rd(3'h3, d);
      chk_reg("result low", fmt(v, just, 1'h0), d);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      for (int k = 0; k < 7; k++) begin
         sac_analog_model_i.level[k] = 10'h000;
      end
      repeat (5) @(posedge i_core_clk);
      i_arst_n <= 1'h1;
      wr(3'h7, 8'hFF);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), d);
         chk_reg("reset or unmapped", 8'h00, d);
      end
      wr(3'h0, 8'h02);
      settle(100);
      rd(3'h0, d);
      chk_reg("start while off", 8'h00, d);
      rd(3'h4, d);
      chk_reg("flag while off", 8'h00, d);
      chk_pin("powered while off", 10'h000, 10'(o_conv_powered));
      $display("test reset and off done");
      for (int j = 0; j < 9; j++) begin
         wr(3'h0, {1'h0, codes[j], 2'h1});
         settle(2);
         chk_pin("source switch", 10'(mux_exp[j]), 10'(o_mux_sel));
      end
      for (int p = 0; p < 4; p++) begin
         wr(3'h1, 8'(p));
         settle(2);
         chk_pin("reference pin", 10'(p == 2), 10'(o_vref_from_pin));
      end
      $display("test selection done");
      for (int i = 0; i < 7; i++) begin
         conv(clks[i], i[0], chans[i], i, 1'h0);
         flag_clear();
      end
      $display("test conversions done");
      wr(3'h1, 8'h60);
      wr(3'h0, 8'h03);
      settle(40);
      pulse(0);
      settle(3);
      chk_pin("powered in sleep", 10'h000, 10'(o_conv_powered));
      rd(3'h0, d);
      chk_reg("abort keeps enable", 8'h01, d);
      settle(800);
      rd(3'h4, d);
      chk_reg("no flag after abort", 8'h00, d);
      pulse(1);
      settle(3);
      chk_pin("powered after wake", 10'h001, 10'(o_conv_powered));
      $display("test sleep abort done");
      wr(3'h5, 8'h40);
      wr(3'h6, 8'h40);
      wakes = 0;
      conv(3'h3, 1'h1, 5'h00, 0, 1'h1);
      chk_pin("wake pulses", 10'h001, 10'(wakes));
      chk_pin("inline resume", 10'h000, 10'(o_vector_req));
      wr(3'h6, 8'hC0);
      settle(3);
      chk_pin("vector before retire", 10'h000, 10'(o_vector_req));
      pulse(2);
      settle(3);
      chk_pin("vector request", 10'h001, 10'(o_vector_req));
      flag_clear();
      settle(3);
      chk_pin("vector withdrawn", 10'h000, 10'(o_vector_req));
      wr(3'h5, 8'h00);
      wakes = 0;
      conv(3'h3, 1'h0, 5'h01, 1, 1'h1);
      settle(3);
      chk_pin("no wake", 10'h000, 10'(wakes));
      chk_pin("parked", 10'h000, 10'(o_conv_powered));
      flag_clear();
      pulse(1);
      $display("test sleep conversions done");
      wrap_up();
   end
   // Watchdog well above the longest run.
   initial begin
      repeat (60000) @(posedge i_core_clk);
      n_errors++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      wrap_up();
   end
endmodule
